// ===== mpio_consts.vh
// Constants for the muxed I/O port unit
`ifndef MPIO_CONSTS_VH
`define MPIO_CONSTS_VH
`define MPIO_AW 3
`define MPIO_DW 16
`define MPIO_PW 8
`define MPIO_ADDR_P1_FUNC 3'h0
`define MPIO_ADDR_P1_DIR 3'h1
`define MPIO_ADDR_P1_LTCH 3'h2
`define MPIO_ADDR_P1_PIN 3'h3
`define MPIO_ADDR_P2_FUNC 3'h4
`define MPIO_ADDR_P2_DIR 3'h5
`define MPIO_ADDR_P2_LTCH 3'h6
`define MPIO_ADDR_P2_PIN 3'h7
`define MPIO_FUNC_RESET 8'hff
`define MPIO_DIR_RESET 8'hff
`define MPIO_LTCH_RESET 8'h00
`define MPIO_PAD_HI 8'h00
// Port 2 pin positions of the shared serial and baud signals
`define MPIO_PIN_RECEIVE 0
`define MPIO_PIN_TRANSMIT 1
`define MPIO_PIN_BAUD1 2
`define MPIO_PIN_INTR 3
`define MPIO_PIN_CLR_SEND 4
`define MPIO_PIN_BAUD0 5
// Lowest open-drain pin; every pin above it is open-drain too
`define MPIO_PIN_OD_LO 6
// Pin kinds
`define MPIO_KIND_BIDIR 2'h0
`define MPIO_KIND_IN 2'h1
`define MPIO_KIND_OUT 2'h2
`define MPIO_KIND_OD 2'h3
`endif

// ===== mpio_sync.v
// Two-flop synchroniser for a vector of pin levels
`timescale 1ns/10ps
`include "mpio_consts.vh"
module mpio_sync (
    input wire clk_i,
    input wire resetn_i,
    input wire [`MPIO_PW-1:0] d_i,
    output wire [`MPIO_PW-1:0] q_o
);
    reg [`MPIO_PW-1:0] meta_q;
    reg [`MPIO_PW-1:0] sync_q;
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_q <= `MPIO_LTCH_RESET;
            sync_q <= `MPIO_LTCH_RESET;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end
    assign q_o = sync_q;
endmodule // mpio_sync

// ===== mpio_pin.v
// One port pin: data and driver-enable muxing by pin kind
`timescale 1ns/10ps
`include "mpio_consts.vh"
module mpio_pin #(
    parameter [1:0] KIND = `MPIO_KIND_BIDIR
) (
    input wire func_i,
    input wire dir_i,
    input wire ltch_i,
    input wire per_out_i,
    input wire per_oe_i,
    output wire pad_o,
    output wire pad_oe_o
);
    wire port_oe;
    wire port_out;
    // Select picks data and enable source together
    assign port_out = func_i ? per_out_i : ltch_i; // RULE1 RULE14
    assign port_oe = func_i ? per_oe_i : ~dir_i; // RULE1 RULE2 RULE3 RULE16
    generate
        if (KIND == `MPIO_KIND_IN) begin : g_in
            assign pad_o = 1'b0;
            assign pad_oe_o = 1'b0; // RULE5
        end else if (KIND == `MPIO_KIND_OUT) begin : g_out
            assign pad_o = port_out;
            assign pad_oe_o = 1'b1; // RULE6 RULE18
        end else if (KIND == `MPIO_KIND_OD) begin : g_od
            // Absent peripheral: mux still exists, pin floats
            assign pad_o = 1'b0;
            assign pad_oe_o = ~func_i & ~dir_i & ~ltch_i; // RULE7 RULE8 RULE9
        end else begin : g_bidir
            assign pad_o = port_out;
            assign pad_oe_o = port_oe;
        end
    endgenerate
endmodule // mpio_pin

// ===== mpio_top.v
// Muxed I/O port unit: two 8-pin ports with register access
// Behaviour
// RULE1: Function select chooses both output data and driver enable source.
// RULE2: Bidirectional port pin with direction zero drives its latch value.
// RULE3: Bidirectional port pin with direction one is an input.
// RULE4: Every pin level is synchronised and readable in any mode.
// RULE5: Input-only pins never drive; direction and latch bits are storage.
// RULE6: Output-only pins always drive peripheral or latch data.
// RULE7: Open-drain output pulls low for latch zero, floats for one.
// RULE8: Open-drain pin floats whenever its direction bit is set.
// RULE9: Open-drain pin floats when absent peripheral function is selected.
// RULE10: Port 1 is eight output-only pins shared with chip selects.
// RULE11: Port 2 mixes kinds; pins 7 and 6 are open-drain.
// RULE12: Port 2 pins 5..0 share serial channel and baud signals.
// RULE13: Each port has select, direction, latch and pin-state registers.
// RULE14: Function select assigns each pin to peripheral or port.
// RULE15: Direction reads return written value, not true direction.
// RULE16: Peripheral-selected pins take direction from the peripheral.
// RULE17: Direction resets to all ones; one is input, zero output.
// RULE18: Output-only direction bit is plain storage.
// RULE19: Latch reads return the latch, not the pin.
// RULE20: Pin-state register is read-only and shows pin levels.
// RULE21: After reset all pins belong to their peripherals.
// RULE22: Select bit one means peripheral; select resets to ones.
// RULE23: Registers are eight bits wide; upper bits read zero.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`include "mpio_consts.vh"
module mpio_top (
    input wire clk_i,
    input wire resetn_i,
    input wire [`MPIO_AW-1:0] addr_i,
    input wire [`MPIO_DW-1:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [`MPIO_DW-1:0] rdata_o,
    input wire [7:0] general_chip_selects_n_i,
    input wire serial_interrupt_out_i,
    input wire serial_transmit_out_i,
    input wire serial_receive_out_i,
    input wire serial_receive_oe_i,
    output wire baud_clock_in_0_o,
    output wire clear_to_send_in_n_o,
    output wire baud_clock_in_1_o,
    output wire serial_receive_in_o,
    input wire [7:0] p1_pad_i,
    output wire [7:0] p1_pad_o,
    output wire [7:0] p1_pad_oe_o,
    input wire [7:0] p2_pad_i,
    output wire [7:0] p2_pad_o,
    output wire [7:0] p2_pad_oe_o
);
    reg [`MPIO_PW-1:0] p1_func_q;
    reg [`MPIO_PW-1:0] p1_dir_q;
    reg [`MPIO_PW-1:0] p1_ltch_q;
    reg [`MPIO_PW-1:0] p2_func_q;
    reg [`MPIO_PW-1:0] p2_dir_q;
    reg [`MPIO_PW-1:0] p2_ltch_q;
    reg [`MPIO_DW-1:0] rdata_d;
    wire [`MPIO_PW-1:0] p1_level;
    wire [`MPIO_PW-1:0] p2_level;
    wire [7:0] p2_per_out;
    wire [7:0] p2_per_oe;

    // Registers; select to peripheral, direction to input at reset
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            p1_func_q <= `MPIO_FUNC_RESET; // RULE21 RULE22
            p2_func_q <= `MPIO_FUNC_RESET; // RULE21 RULE22
            p1_dir_q <= `MPIO_DIR_RESET; // RULE17
            p2_dir_q <= `MPIO_DIR_RESET; // RULE17
            p1_ltch_q <= `MPIO_LTCH_RESET;
            p2_ltch_q <= `MPIO_LTCH_RESET;
        end else if (wr_i) begin
            case (addr_i) // RULE13
                `MPIO_ADDR_P1_FUNC: p1_func_q <= wdata_i[`MPIO_PW-1:0];
                `MPIO_ADDR_P1_DIR: p1_dir_q <= wdata_i[`MPIO_PW-1:0]; // RULE15
                `MPIO_ADDR_P1_LTCH: p1_ltch_q <= wdata_i[`MPIO_PW-1:0];
                `MPIO_ADDR_P2_FUNC: p2_func_q <= wdata_i[`MPIO_PW-1:0];
                `MPIO_ADDR_P2_DIR: p2_dir_q <= wdata_i[`MPIO_PW-1:0]; // RULE15
                `MPIO_ADDR_P2_LTCH: p2_ltch_q <= wdata_i[`MPIO_PW-1:0];
                default: begin
                end
            endcase
        end
    end

    // Pin-state writes are dropped; reads stand one cycle only
    always @* begin
        rdata_d = {`MPIO_DW{1'b0}};
        if (rd_i) begin
            case (addr_i)
                `MPIO_ADDR_P1_FUNC: rdata_d = {`MPIO_PAD_HI, p1_func_q}; // RULE23
                `MPIO_ADDR_P1_DIR: rdata_d = {`MPIO_PAD_HI, p1_dir_q}; // RULE15
                `MPIO_ADDR_P1_LTCH: rdata_d = {`MPIO_PAD_HI, p1_ltch_q}; // RULE19
                `MPIO_ADDR_P1_PIN: rdata_d = {`MPIO_PAD_HI, p1_level}; // RULE20
                `MPIO_ADDR_P2_FUNC: rdata_d = {`MPIO_PAD_HI, p2_func_q};
                `MPIO_ADDR_P2_DIR: rdata_d = {`MPIO_PAD_HI, p2_dir_q};
                `MPIO_ADDR_P2_LTCH: rdata_d = {`MPIO_PAD_HI, p2_ltch_q};
                `MPIO_ADDR_P2_PIN: rdata_d = {`MPIO_PAD_HI, p2_level}; // RULE20
                default: rdata_d = {`MPIO_DW{1'b0}};
            endcase
        end
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= {`MPIO_DW{1'b0}};
        end else begin
            rdata_o <= rdata_d;
        end
    end

    // Levels sampled in every mode, so software can watch peripheral pins too
    mpio_sync u_sync1 (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .d_i(p1_pad_i),
        .q_o(p1_level) // RULE4
    );
    mpio_sync u_sync2 (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .d_i(p2_pad_i),
        .q_o(p2_level) // RULE4
    );

    // Port 2 peripheral sources; inputs offer no drive
    assign p2_per_out = {1'b0, 1'b0, 1'b0, 1'b0, serial_interrupt_out_i, 1'b0,
                         serial_transmit_out_i, serial_receive_out_i}; // RULE12
    assign p2_per_oe = {1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1,
                        serial_receive_oe_i}; // RULE12

    // Peripheral inputs see the synchronised pin level
    assign baud_clock_in_0_o = p2_level[`MPIO_PIN_BAUD0]; // RULE12
    assign clear_to_send_in_n_o = p2_level[`MPIO_PIN_CLR_SEND];
    assign baud_clock_in_1_o = p2_level[`MPIO_PIN_BAUD1];
    assign serial_receive_in_o = p2_level[`MPIO_PIN_RECEIVE];

    genvar i;
    generate
        for (i = 0; i < `MPIO_PW; i = i + 1) begin : g_pin
            mpio_pin #(
                .KIND(`MPIO_KIND_OUT) // RULE10
            ) u_p1 (
                .func_i(p1_func_q[i]),
                .dir_i(p1_dir_q[i]),
                .ltch_i(p1_ltch_q[i]),
                .per_out_i(general_chip_selects_n_i[i]),
                .per_oe_i(1'b1),
                .pad_o(p1_pad_o[i]),
                .pad_oe_o(p1_pad_oe_o[i])
            );
            // Kind per pin: 7,6 open-drain; 5,4,2 in; 3,1 out; 0 bidir
            mpio_pin #(
                .KIND((i >= `MPIO_PIN_OD_LO) ? `MPIO_KIND_OD :
                      (i == `MPIO_PIN_BAUD0 || i == `MPIO_PIN_CLR_SEND || i == `MPIO_PIN_BAUD1) ?
                      `MPIO_KIND_IN :
                      (i == `MPIO_PIN_INTR || i == `MPIO_PIN_TRANSMIT) ? `MPIO_KIND_OUT :
                      `MPIO_KIND_BIDIR) // RULE11
            ) u_p2 (
                .func_i(p2_func_q[i]),
                .dir_i(p2_dir_q[i]),
                .ltch_i(p2_ltch_q[i]),
                .per_out_i(p2_per_out[i]),
                .per_oe_i(p2_per_oe[i]),
                .pad_o(p2_pad_o[i]),
                .pad_oe_o(p2_pad_oe_o[i])
            );
        end
    endgenerate
endmodule // mpio_top

// ===== mpio_props.sv
// Pin and read-back assertions for the port unit
`timescale 1ns/10ps
module mpio_props (
    input wire clk_i, resetn_i, wr_i, rd_i, serial_receive_oe_i,
    input wire [2:0] addr_i,
    input wire [15:0] wdata_i, rdata_o,
    input wire [7:0] general_chip_selects_n_i, p1_pad_i, p1_pad_o, p1_pad_oe_o, p2_pad_oe_o
);
    reg [7:0] sh_q [0:7];
    integer i;
    // Shadow of the writable registers, so no internals are needed
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (i = 0; i < 8; i = i + 1) sh_q[i] <= (i % 4 == 2) ? 8'h00 : 8'hff;
        end else if (wr_i && addr_i[1:0] != 2'h3) begin
            sh_q[addr_i] <= wdata_i[7:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_p1_drive: assert property (p1_pad_oe_o == 8'hff) else $error("p1 oe");
    a_p1_mux: assert property (p1_pad_o ==
        (sh_q[0] & general_chip_selects_n_i | ~sh_q[0] & sh_q[2])) else $error("p1 data");
    a_in_float: assert property (p2_pad_oe_o[5:4] == 2'h0 && !p2_pad_oe_o[2])
        else $error("input drives");
    a_od_pull: assert property (p2_pad_oe_o[7:6] ==
        ~(sh_q[4][7:6] | sh_q[5][7:6] | sh_q[6][7:6])) else $error("open drain");
    a_bidir_oe: assert property (p2_pad_oe_o[0] ==
        (sh_q[4][0] ? serial_receive_oe_i : !sh_q[5][0])) else $error("pin0 oe");
    a_readback: assert property (rd_i && addr_i[1:0] != 2'h3 |=>
        rdata_o == {8'h00, sh_q[$past(addr_i)]}) else $error("readback");
    a_pin_state: assert property (rd_i && addr_i == 3'h3 && $stable(p1_pad_i)
        && $past(p1_pad_i, 2) == p1_pad_i |=> rdata_o == {8'h00, $past(p1_pad_i)})
        else $error("pin state");
    a_rd_idle: assert property (!rd_i |=> rdata_o == 16'h0000) else $error("stale read");
    c_od_low: cover property (p2_pad_oe_o[6]);
    c_bidir_out: cover property (p2_pad_oe_o[0] && !sh_q[4][0]);
    c_pin_read: cover property (rd_i && addr_i == 3'h3);
endmodule // mpio_props
bind mpio_top mpio_props u_props (.clk_i(clk_i), .resetn_i(resetn_i), .wr_i(wr_i),
    .rd_i(rd_i), .serial_receive_oe_i(serial_receive_oe_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .general_chip_selects_n_i(general_chip_selects_n_i),
    .p1_pad_i(p1_pad_i), .p1_pad_o(p1_pad_o), .p1_pad_oe_o(p1_pad_oe_o),
    .p2_pad_oe_o(p2_pad_oe_o));

// ===== mpio_pads.sv
// Board side of the pads: outside drivers and pull-ups
`timescale 1ns/10ps
module mpio_pads (
    input wire [7:0] p1_pad_o, p1_pad_oe_o, p2_pad_o, p2_pad_oe_o, ext_i,
    output wire [7:0] p1_pad_i, p2_pad_i
);
    // A released pin shows the outside level, never its last driven value
    assign p1_pad_i = p1_pad_oe_o & p1_pad_o | ~p1_pad_oe_o & ext_i;
    // Pins 7:6 are pulled up; ext_i low stands for another open-drain driver
    assign p2_pad_i = {~p2_pad_oe_o[7:6] & ext_i[7:6],
        p2_pad_oe_o[5:0] & p2_pad_o[5:0] | ~p2_pad_oe_o[5:0] & ext_i[5:0]};
endmodule // mpio_pads

// ===== mpio_top_tb.sv
// Self-checking bench for the port unit
`timescale 1ns/10ps
module mpio_top_tb;
    reg clk_i = 0, rst_n = 0, wr = 0, rd = 0, sint = 0, stx = 1, srx_oe = 0;
    reg [2:0] ad = 0;
    reg [15:0] wd = 0;
    reg [7:0] gcs = 8'ha5, ext = 8'h5a;
    wire [15:0] rdat;
    wire [7:0] p1i, p1o, p1e, p2i, p2o, p2e;
    wire [3:0] sy;
    integer err_count = 0, n_tests = 0;
    always #5 clk_i = ~clk_i;
    mpio_top DUT (.clk_i(clk_i), .resetn_i(rst_n), .addr_i(ad), .wdata_i(wd), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdat), .general_chip_selects_n_i(gcs), .serial_interrupt_out_i(sint),
        .serial_transmit_out_i(stx), .serial_receive_out_i(sint), .serial_receive_oe_i(srx_oe),
        .baud_clock_in_0_o(sy[3]), .clear_to_send_in_n_o(sy[2]), .baud_clock_in_1_o(sy[1]),
        .serial_receive_in_o(sy[0]), .p1_pad_i(p1i), .p1_pad_o(p1o), .p1_pad_oe_o(p1e),
        .p2_pad_i(p2i), .p2_pad_o(p2o), .p2_pad_oe_o(p2e));
    mpio_pads PM (.p1_pad_o(p1o), .p1_pad_oe_o(p1e), .p2_pad_o(p2o), .p2_pad_oe_o(p2e),
        .ext_i(ext), .p1_pad_i(p1i), .p2_pad_i(p2i));
    task chk(input [15:0] got, input [15:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Read when w is low, with d as the expected read data
    task bus(input w, input [2:0] a, input [15:0] d);
        @(posedge clk_i);
        ad <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk_i);
        wr <= 1'b0;
        rd <= 1'b0;
        @(negedge clk_i);
        if (!w) chk(rdat, d);
    endtask
    task t_reset;
        for (int a = 0; a < 7; a++) begin
            if (a % 4 != 3)
                bus(1'b0, a[2:0], (a % 4 == 2) ? 16'h0000 : 16'h00ff);
        end
        chk({p1e, p2e}, {8'hff, 8'h0a});
        chk({p1o, p2o & 8'h0a}, {gcs, 8'h02});
        $display("t_reset done");
    endtask
    task t_p1;
        bus(1'b1, 3'h2, 16'hff05);
        bus(1'b1, 3'h0, 16'h00f0);
        bus(1'b1, 3'h1, 16'h005a);
        bus(1'b1, 3'h3, 16'h0012);
        chk({p1o, p1e}, {gcs[7:4], 4'h5, 8'hff});
        bus(1'b0, 3'h1, 16'h005a);
        bus(1'b0, 3'h2, 16'h0005);
        bus(1'b0, 3'h3, {8'h00, gcs[7:4], 4'h5});
        $display("t_p1 done");
    endtask
    task t_p2;
        bus(1'b1, 3'h6, 16'h0081);
        bus(1'b1, 3'h5, 16'h003e);
        bus(1'b1, 3'h4, 16'h0000);
        chk({p2e, p2o & 8'h0b}, {8'h4b, 8'h01});
        bus(1'b1, 3'h5, 16'h00ff);
        chk({8'h00, p2e}, 16'h000a);
        bus(1'b1, 3'h5, 16'h003e);
        bus(1'b1, 3'h4, 16'h00c1);
        chk({8'h00, p2e}, 16'h000a);
        @(posedge clk_i);
        srx_oe <= 1'b1;
        @(negedge clk_i);
        chk({8'h00, p2e}, 16'h000b);
        @(posedge clk_i);
        sint <= 1'b1;
        @(negedge clk_i);
        chk({8'h00, p2o & 8'h09}, 16'h0001);
        $display("t_p2 done");
    endtask
    task t_pins;
        @(posedge clk_i);
        ext <= 8'ha5;
        repeat (3) @(posedge clk_i);
        bus(1'b0, 3'h7, 16'h00a5);
        chk({12'h000, sy}, 16'h000b);
        $display("t_pins done");
    endtask
    task test_done;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        err_count = err_count + 1;
        test_done;
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_n <= 1'b1;
        t_reset;
        t_p1;
        t_p2;
        t_pins;
        test_done;
    end
endmodule // mpio_top_tb
